// File: pkg/decim_regs_map.vh
`ifndef DECIM_REGS_MAP_VH
`define DECIM_REGS_MAP_VH

`define ADDR_RESERVED_ZERO   7'h14
`define ADDR_STATUS_FLAGS    7'h15
`define ADDR_INT_LOW         7'h16
`define ADDR_INT_MID         7'h17
`define ADDR_INT_HIGH        7'h18
`define ADDR_FRAC_LOW        7'h19
`define ADDR_FRAC_MID0       7'h1a
`define ADDR_FRAC_MID1       7'h1b
`define ADDR_FRAC_HIGH       7'h1c

`define RST_STATUS_FLAGS     8'h00
`define RST_INT_LOW          8'h40
`define RST_INT_MID          8'h00
`define RST_INT_HIGH         8'h00
`define RST_FRAC_LOW         8'h72
`define RST_FRAC_MID0        8'hb7
`define RST_FRAC_MID1        8'hce
`define RST_FRAC_HIGH        8'h2b

`define BIT_GATING           5
`define BIT_DIRECTION        4
`define BIT_MODE             3
`define BIT_CLKSRC           2
`define BIT_FUSE_ECC         1
`define BIT_PLL_LOCK         0

`endif

// File: rtl/rate_accumulator.v
`timescale 1ns/1ps
// Fractional divider: phase advances by one master clock per cycle.
// Wraps when the 24.32 phase reaches the programmed rate.
module rate_accumulator (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        run,
  input  wire [55:0] rate,
  output reg         tick
);
  reg  [56:0] phase_reg;
  reg  [56:0] phase_next;
  // One master clock is 1.0 in 24.32 fixed point
  wire [56:0] one_step = 57'h1_0000_0000;
  wire [56:0] rate_ext = {1'b0, rate};

  always @* begin
    phase_next = phase_reg + one_step;
    if (phase_next >= rate_ext) begin
      phase_next = phase_next - rate_ext;
    end
  end

  always @(posedge sys_clk) begin
    if (srst || !run) begin
      phase_reg <= 57'h0;
      tick      <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      tick      <= (phase_reg + one_step) >= rate_ext;
    end
  end
endmodule

// File: rtl/status_and_decimation_rate_regs.v
`timescale 1ns/1ps
`include "decim_regs_map.vh"
module status_and_decimation_rate_regs (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire [6:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       data_clock_gating_strap,
  input  wire       data_clock_direction_strap,
  input  wire       mode_strap,
  input  wire       clock_source_strap,
  input  wire       fuse_ecc_event,
  input  wire       pll_locked,
  output reg        sample_rate_pin,
  output reg        sample_rate_pin_oe_n,
  output reg  [23:0] decim_integer_value,
  output reg  [31:0] decim_fraction_value
);
  reg  [7:0] decim_integer_low_reg;
  reg  [7:0] decim_integer_mid_reg;
  reg  [7:0] decim_integer_high_reg;
  reg  [7:0] decim_fraction_low_reg;
  reg  [7:0] decim_fraction_mid0_reg;
  reg  [7:0] decim_fraction_mid1_reg;
  reg  [7:0] decim_fraction_high_reg;
  reg  [5:0] strap_reg;
  reg        fuse_ecc_reg;
  reg  [7:0] rdata_next;
  wire       rate_tick;
  wire [7:0] status_view;

  // Straps are caught every cycle after reset, never inside reset
  always @(posedge sys_clk) begin
    if (srst) begin
      strap_reg <= 6'h00;
    end else begin
      strap_reg[`BIT_GATING]    <= data_clock_gating_strap;
      strap_reg[`BIT_DIRECTION] <= data_clock_direction_strap;
      strap_reg[`BIT_MODE]      <= mode_strap;
      strap_reg[`BIT_CLKSRC]    <= clock_source_strap;
      strap_reg[`BIT_PLL_LOCK]  <= pll_locked;
      strap_reg[`BIT_FUSE_ECC]  <= 1'b0;
    end
  end

  // sticky, set wins over read clear
  always @(posedge sys_clk) begin
    if (srst) begin
      fuse_ecc_reg <= 1'b0;
    end else if (fuse_ecc_event) begin
      fuse_ecc_reg <= 1'b1;
    end else if (reg_rd && reg_addr == `ADDR_STATUS_FLAGS) begin
      fuse_ecc_reg <= 1'b0;
    end
  end

  assign status_view = {2'b00, strap_reg[5:2], fuse_ecc_reg, strap_reg[0]};

  // byte writes, status and reserved writes dropped
  always @(posedge sys_clk) begin
    if (srst) begin
      decim_integer_low_reg   <= `RST_INT_LOW;
      decim_integer_mid_reg   <= `RST_INT_MID;
      decim_integer_high_reg  <= `RST_INT_HIGH;
      decim_fraction_low_reg  <= `RST_FRAC_LOW;
      decim_fraction_mid0_reg <= `RST_FRAC_MID0;
      decim_fraction_mid1_reg <= `RST_FRAC_MID1;
      decim_fraction_high_reg <= `RST_FRAC_HIGH;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_INT_LOW) begin
        decim_integer_low_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_INT_MID) begin
        decim_integer_mid_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_INT_HIGH) begin
        decim_integer_high_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_FRAC_LOW) begin
        decim_fraction_low_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_FRAC_MID0) begin
        decim_fraction_mid0_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_FRAC_MID1) begin
        decim_fraction_mid1_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_FRAC_HIGH) begin
        decim_fraction_high_reg <= reg_wdata;
      end
    end
  end

  always @* begin
    rdata_next = 8'h00;
    if (reg_addr == `ADDR_STATUS_FLAGS) begin
      rdata_next = status_view;
    end else if (reg_addr == `ADDR_INT_LOW) begin
      rdata_next = decim_integer_low_reg;
    end else if (reg_addr == `ADDR_INT_MID) begin
      rdata_next = decim_integer_mid_reg;
    end else if (reg_addr == `ADDR_INT_HIGH) begin
      rdata_next = decim_integer_high_reg;
    end else if (reg_addr == `ADDR_FRAC_LOW) begin
      rdata_next = decim_fraction_low_reg;
    end else if (reg_addr == `ADDR_FRAC_MID0) begin
      rdata_next = decim_fraction_mid0_reg;
    end else if (reg_addr == `ADDR_FRAC_MID1) begin
      rdata_next = decim_fraction_mid1_reg;
    end else if (reg_addr == `ADDR_FRAC_HIGH) begin
      rdata_next = decim_fraction_high_reg;
    end
  end

  // Read data registered; reserved byte and unmapped read zero
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // rate assembled as 24.32 fixed point
  always @(posedge sys_clk) begin
    if (srst) begin
      decim_integer_value  <= {`RST_INT_HIGH, `RST_INT_MID, `RST_INT_LOW};
      decim_fraction_value <= {`RST_FRAC_HIGH, `RST_FRAC_MID1, `RST_FRAC_MID0, `RST_FRAC_LOW};
    end else begin
      decim_integer_value  <= {decim_integer_high_reg, decim_integer_mid_reg,
                               decim_integer_low_reg};
      decim_fraction_value <= {decim_fraction_high_reg, decim_fraction_mid1_reg,
                               decim_fraction_mid0_reg, decim_fraction_low_reg};
    end
  end

  // divider runs only in master mode; rates below one would stall
  rate_accumulator u_rate (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (strap_reg[`BIT_MODE] && decim_integer_value != 24'h000000),
    .rate    ({decim_integer_value, decim_fraction_value}),
    .tick    (rate_tick)
  );

  // pulse out, pin released in slave mode
  always @(posedge sys_clk) begin
    if (srst) begin
      sample_rate_pin      <= 1'b0;
      sample_rate_pin_oe_n <= 1'b1;
    end else begin
      sample_rate_pin      <= rate_tick;
      sample_rate_pin_oe_n <= ~strap_reg[`BIT_MODE];
    end
  end
endmodule

// File: test/rate_regs_sva.sv
`timescale 1ns/1ps
module rate_regs_sva (
  input wire        sys_clk,
  input wire        srst,
  input wire [6:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        mode_strap,
  input wire        fuse_ecc_event,
  input wire        sample_rate_pin,
  input wire        sample_rate_pin_oe_n,
  input wire [23:0] decim_integer_value,
  input wire [31:0] decim_fraction_value
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire st = reg_rd && reg_addr == 7'h15;
  AST_RSVD_BYTE: assert property (reg_rd && reg_addr == 7'h14 |=> reg_rdata == 8'h00)
    else $error("reserved byte nonzero");
  AST_FUSE_CLR: assert property (st && !fuse_ecc_event ##1 !fuse_ecc_event ##1 st && !fuse_ecc_event |=> !reg_rdata[1])
    else $error("fuse flag not cleared");
  AST_FUSE_SET: assert property (fuse_ecc_event ##1 !st ##1 st |=> reg_rdata[1])
    else $error("fuse flag not set");
  AST_MODE_BIT: assert property (st |=> reg_rdata[3] == $past(mode_strap, 2))
    else $error("mode bit wrong");
  AST_INT_LOW: assert property (reg_wr && reg_addr == 7'h16 |=> ##1 decim_integer_value[7:0] == $past(reg_wdata, 2))
    else $error("integer low byte wrong");
  AST_FRAC_HI: assert property (reg_wr && reg_addr == 7'h1c |=> ##1 decim_fraction_value[31:24] == $past(reg_wdata, 2))
    else $error("fraction high byte wrong");
  AST_SLAVE_OFF: assert property (!mode_strap [*4] |-> sample_rate_pin_oe_n && !sample_rate_pin)
    else $error("pin active in slave");
  AST_MASTER_ON: assert property (mode_strap [*4] |-> !sample_rate_pin_oe_n)
    else $error("pin idle in master");
  AST_STATUS_TOP: assert property (st |=> reg_rdata[7:6] == 2'b00)
    else $error("status reserved bits nonzero");
  cover property (st ##2 st);
  cover property (sample_rate_pin);
  cover property (reg_wr && reg_addr == 7'h1c);
endmodule

// File: test/host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
  input  wire       sys_clk,
  input  wire [7:0] reg_rdata,
  output reg  [6:0] reg_addr,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_wdata
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Stale data inverted so a late sample shows
      reg_wdata <= ~d;
    end
  endtask
  task rd(input [6:0] a, output [7:0] q);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
    end
  endtask
endmodule

// File: test/status_and_decimation_rate_regs_tb_top.sv
`timescale 1ns/1ps
module status_and_decimation_rate_regs_tb_top;
  reg         sys_clk = 1'b0;
  reg         srst = 1'b1;
  reg  [3:0]  straps = 4'h9;
  reg         fuse = 1'b0;
  reg         lock = 1'b1;
  wire [6:0]  addr;
  wire        wr;
  wire        rd;
  wire [7:0]  wdata;
  wire [7:0]  rdata;
  wire        pin;
  wire        oe_n;
  wire [55:0] rate_seen;
  integer     errors = 0;
  integer     n_compared = 0;
  integer     cyc = 0;
  integer     i;
  reg  [7:0]  q;
  reg  [7:0]  p;
  localparam [55:0] rst_tab = 56'h2bceb772000040;
  // Rate 4.5: periods alternate, pairs sum to 9
  localparam [55:0] rate_tab = 56'h80000000000004;
  always #5 sys_clk = ~sys_clk;
  host_port_model u_host (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata));
  status_and_decimation_rate_regs u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .data_clock_gating_strap(straps[3]), .data_clock_direction_strap(straps[2]),
    .mode_strap(straps[1]), .clock_source_strap(straps[0]), .fuse_ecc_event(fuse),
    .pll_locked(lock), .sample_rate_pin(pin), .sample_rate_pin_oe_n(oe_n),
    .decim_integer_value(rate_seen[23:0]), .decim_fraction_value(rate_seen[55:24]));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wait_pin(output [7:0] c);
    begin
      c = 8'h00;
      do begin
        @(posedge sys_clk);
        #1 c = c + 8'h01;
      end while (pin !== 1'b1 && c < 8'h3c);
    end
  endtask
  task results;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Whole run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    u_host.rd(7'h15, q);
    chk(q, {2'b00, straps, 1'b0, lock});
    for (i = 0; i < 7; i = i + 1) begin
      u_host.rd(i[6:0] + 7'h16, q);
      chk(q, rst_tab[8*i +: 8]);
      chk(rate_seen[8*i +: 8], rst_tab[8*i +: 8]);
    end
    $display("reset test done");
    u_host.wr(7'h15, 8'hff);
    u_host.wr(7'h14, 8'hff);
    u_host.rd(7'h14, q);
    chk(q, 8'h00);
    @(posedge sys_clk);
    straps <= 4'h6;
    lock <= 1'b0;
    fuse <= 1'b1;
    @(posedge sys_clk);
    fuse <= 1'b0;
    u_host.rd(7'h15, q);
    chk(q, 8'h1a);
    u_host.rd(7'h15, q);
    chk(q, 8'h18);
    // Fuse event on the read edge: set must win over the clear
    fork
      u_host.rd(7'h15, q);
      begin
        @(posedge sys_clk);
        fuse <= 1'b1;
        @(posedge sys_clk);
        fuse <= 1'b0;
      end
    join
    chk(q, 8'h18);
    u_host.rd(7'h15, q);
    chk(q, 8'h1a);
    $display("status test done");
    for (i = 0; i < 7; i = i + 1)
      u_host.wr(i[6:0] + 7'h16, rate_tab[8*i +: 8]);
    u_host.rd(7'h1c, q);
    chk(q, 8'h80);
    for (i = 0; i < 7; i = i + 1)
      chk(rate_seen[8*i +: 8], rate_tab[8*i +: 8]);
    wait_pin(q);
    wait_pin(q);
    wait_pin(p);
    chk(q + p, 8'h09);
    chk({7'h00, oe_n}, 8'h00);
    $display("rate test done");
    results;
  end
endmodule
bind status_and_decimation_rate_regs rate_regs_sva u_sva (.sys_clk(sys_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .mode_strap(mode_strap), .fuse_ecc_event(fuse_ecc_event),
  .sample_rate_pin(sample_rate_pin), .sample_rate_pin_oe_n(sample_rate_pin_oe_n),
  .decim_integer_value(decim_integer_value), .decim_fraction_value(decim_fraction_value));
